// [shared/gtimer_defines.svh]
// constants of the joined general-purpose timer: codes, fields, resets
`ifndef GTIMER_DEFINES_SVH
`define GTIMER_DEFINES_SVH

// ==========================================================
// configuration codes
`define CFG_32_TIMER 3'h0
`define CFG_32_RTC 3'h1
`define CFG_16_SPLIT 3'h4

// ==========================================================
// mode field codes
`define MODE_ONESHOT 2'h1
`define MODE_PERIODIC 2'h2

// ==========================================================
// control register bit positions
`define CTL_A_EN 0
`define CTL_A_STALL 1
`define CTL_RTC_OVR 4
`define CTL_A_OTE 5
`define CTL_B_EN 8
`define CTL_B_STALL 9
`define CTL_B_OTE 13

// ==========================================================
// status, mask and clear bit positions
`define IRQ_A_TO 0
`define IRQ_RTC 3
`define IRQ_B_TO 8

// ==========================================================
// reset values
`define CFG_RST 3'h0
`define MODE_RST 2'h0
`define CTL_RST 16'h0000
`define IMR_RST 16'h0000
`define STAT_RST 16'h0000
`define CNT_RST 16'hFFFF
`define ILR_RST 16'hFFFF
`define PRE_RST 8'h00
`define MATCH_RST 32'h00000000
`define RTC_FIRST_LO 16'h0001
`define RTC_FIRST_HI 16'h0000
`define RTC_ROLL 16'h0000

// ==========================================================
// real-time-clock divide: input edges per output second
`define RTC_IN_HZ 32768
`define RTC_OUT_HZ 1
`define RTC_DIV (`RTC_IN_HZ / `RTC_OUT_HZ)

`endif

// [shared/gtimer_pkg.sv]
// types shared by the general-purpose timer modules
package gtimer_pkg;
   typedef enum logic [1:0] {
      CNT_HOLD,
      CNT_LOAD,
      CNT_DEC,
      CNT_INC
   } cnt_cmd_t;
endpackage : gtimer_pkg

// [shared/cnt_if.sv]
// command and count link between timer control and one 16-bit counter
`timescale 1ns/1ps
`default_nettype none
interface cnt_if;
   gtimer_pkg::cnt_cmd_t cmd;
   logic [15:0] value;
   logic [15:0] count;
   modport ctl (output cmd, output value, input count);
   modport cnt (input cmd, input value, output count);
endinterface : cnt_if
`default_nettype wire

// [core/counter16.sv]
// one 16-bit up/down counter slice with load
`timescale 1ns/1ps
`default_nettype none
`include "gtimer_defines.svh"
module counter16 (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command side
   cnt_if.cnt port
);
   logic [15:0] count_reg;
   logic [15:0] count_next;

   always_comb begin
      count_next = count_reg;
      case (port.cmd)
         gtimer_pkg::CNT_LOAD: count_next = port.value;
         gtimer_pkg::CNT_DEC: count_next = count_reg - 16'h0001;
         gtimer_pkg::CNT_INC: count_next = count_reg + 16'h0001;
         default: count_next = count_reg;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_reg <= `CNT_RST; // [R5]
      end else begin
         count_reg <= count_next;
      end
   end

   assign port.count = count_reg;
endmodule : counter16
`default_nettype wire

// [core/general_timer_module.sv]
// general-purpose timer: two 16-bit counters, 32-bit timer and rtc modes
// Functional notes
// [R1] two 16-bit counters run alone or join as 32-bit timer or rtc
// [R2] own adc trigger is ORed with other timers' triggers
// [R3] 32-bit configuration acts as one timer; split lets each act alone
// [R4] reset leaves the timer idle with control registers at defaults
// [R5] reset sets both counters and both interval loads to 0xFFFF
// [R6] reset clears both prescale registers
// [R7] config 0 selects 32-bit timer, config 1 selects 32-bit rtc
// [R8] config 4 selects split 16-bit operation
// [R9] 32-bit load write: low half to a, high half to b
// [R10] 32-bit value read returns b in upper half, a in lower
// [R11] 32-bit timer uses only counter a mode field
// [R12] setting a enable starts the down count from the loaded value
// [R13] at zero reload next cycle; one-shot stops and clears enable
// [R14] zero sets raw timeout flag a, held until software clears
// [R15] unmasked timeout also shows in masked status
// [R16] timeout pulses adc trigger only while trigger enable set
// [R17] load rewrite while running is taken next cycle
// [R18] stall bit freezes counting during debug halt
// [R19] first rtc entry loads one; later values via match register
// [R20] 32.768 kHz pin input divided to 1 Hz count increments
// [R21] rtc rolls to zero on match, keeps counting until disabled
// [R22] rtc match sets raw and masked flags; clear bit clears both
// [R23] rtc stall override keeps rtc counting during debug halt
// [R24] rtc pin is synchronised and edge detected on system clock
`timescale 1ns/1ps
`default_nettype none
`include "gtimer_defines.svh"
module general_timer_module #(
   parameter int RTC_DIV = `RTC_DIV
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // system
   input wire logic DBG_HALT,
   input wire logic ADC_TRIG_IN,
   input wire logic CAPTURE_PIN_EVEN_0,
   // configuration writes
   input wire logic CFG_WR,
   input wire logic [2:0] CFG_WDATA,
   input wire logic A_MODE_WR,
   input wire logic [1:0] A_MODE_WDATA,
   input wire logic B_MODE_WR,
   input wire logic [1:0] B_MODE_WDATA,
   input wire logic CTL_WR,
   input wire logic [15:0] CTL_WDATA,
   // load, match and prescale writes
   input wire logic ILR_A_WR,
   input wire logic [31:0] ILR_A_WDATA,
   input wire logic ILR_B_WR,
   input wire logic [15:0] ILR_B_WDATA,
   input wire logic MATCH_A_WR,
   input wire logic [31:0] MATCH_A_WDATA,
   input wire logic PRE_A_WR,
   input wire logic [7:0] PRE_A_WDATA,
   input wire logic PRE_B_WR,
   input wire logic [7:0] PRE_B_WDATA,
   // interrupt mask and clear writes
   input wire logic IMR_WR,
   input wire logic [15:0] IMR_WDATA,
   input wire logic ICR_WR,
   input wire logic [15:0] ICR_WDATA,
   // register readback
   output logic [2:0] TIMER_CONFIG_REG,
   output logic [1:0] COUNTER_A_MODE_REG,
   output logic [1:0] COUNTER_B_MODE_REG,
   output logic [15:0] TIMER_CONTROL_REG,
   output logic [31:0] COUNTER_A_INTERVAL_LOAD,
   output logic [15:0] COUNTER_B_INTERVAL_LOAD,
   output logic [31:0] COUNTER_A_MATCH,
   output logic [7:0] COUNTER_A_PRESCALE,
   output logic [7:0] COUNTER_B_PRESCALE,
   output logic [15:0] IRQ_MASK_REG,
   // state
   output logic [31:0] COUNTER_A_VALUE,
   output logic [15:0] COUNTER_B_VALUE,
   output logic [15:0] RAW_IRQ_STATUS,
   output logic [15:0] MASKED_IRQ_STATUS,
   output logic IRQ,
   output logic ADC_TRIG
);
   localparam int DIV_W = (RTC_DIV > 1) ? $clog2(RTC_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RTC_DIV - 1);

   // ==========================================================
   // counter slices
   cnt_if a_if ();
   cnt_if b_if ();
   counter16 u_cnt_a (.clk(CLK), .rst(RST), .port(a_if.cnt)); // [R1]
   counter16 u_cnt_b (.clk(CLK), .rst(RST), .port(b_if.cnt));

   // ==========================================================
   // configuration state
   logic [2:0] cfg_reg, cfg_next;
   logic [1:0] amode_reg, amode_next, bmode_reg, bmode_next;
   logic [15:0] ctl_reg, ctl_next, imr_reg, imr_next;
   logic [15:0] ris_reg, ris_next;
   logic [15:0] ilr_a_reg, ilr_a_next, ilr_b_reg, ilr_b_next;
   logic [31:0] match_reg, match_next;
   logic [7:0] pre_a_reg, pre_a_next, pre_b_reg, pre_b_next;
   logic adc_reg, adc_next;
   // events from the counting logic
   logic a_to, b_to, rtc_hit, a_done, b_done, rtc_entry;

   always_comb begin
      cfg_next = cfg_reg;
      amode_next = amode_reg;
      bmode_next = bmode_reg;
      ctl_next = ctl_reg;
      imr_next = imr_reg;
      ilr_a_next = ilr_a_reg;
      ilr_b_next = ilr_b_reg;
      match_next = match_reg;
      pre_a_next = pre_a_reg;
      pre_b_next = pre_b_reg;
      if (CFG_WR) cfg_next = CFG_WDATA; // [R7] [R8]
      if (A_MODE_WR) amode_next = A_MODE_WDATA;
      if (B_MODE_WR) bmode_next = B_MODE_WDATA;
      if (CTL_WR) ctl_next = CTL_WDATA;
      if (IMR_WR) imr_next = IMR_WDATA;
      if (MATCH_A_WR) match_next = MATCH_A_WDATA;
      if (PRE_A_WR) pre_a_next = PRE_A_WDATA;
      if (PRE_B_WR) pre_b_next = PRE_B_WDATA;
      if (ILR_A_WR) begin
         ilr_a_next = ILR_A_WDATA[15:0];
         // joined modes split the word over both loads
         if (cfg_reg != `CFG_16_SPLIT) begin
            ilr_b_next = ILR_A_WDATA[31:16]; // [R9]
         end
      end
      if (ILR_B_WR) ilr_b_next = ILR_B_WDATA;
      // hardware stop of a one-shot beats a same-cycle software write
      if (a_done) ctl_next[`CTL_A_EN] = 1'b0; // [R13]
      if (b_done) ctl_next[`CTL_B_EN] = 1'b0;
      // set wins over clear
      ris_next = ris_reg;
      if (ICR_WR) ris_next = ris_reg & ~ICR_WDATA; // [R14] [R22]
      if (a_to) ris_next[`IRQ_A_TO] = 1'b1; // [R14]
      if (b_to) ris_next[`IRQ_B_TO] = 1'b1;
      if (rtc_hit) ris_next[`IRQ_RTC] = 1'b1; // [R22]
      adc_next = (a_to & ctl_reg[`CTL_A_OTE])
         | (b_to & ctl_reg[`CTL_B_OTE]); // [R16]
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         cfg_reg <= `CFG_RST; // [R4]
         amode_reg <= `MODE_RST;
         bmode_reg <= `MODE_RST;
         ctl_reg <= `CTL_RST;
         imr_reg <= `IMR_RST;
         ris_reg <= `STAT_RST;
         ilr_a_reg <= `ILR_RST; // [R5]
         ilr_b_reg <= `ILR_RST;
         match_reg <= `MATCH_RST;
         pre_a_reg <= `PRE_RST; // [R6]
         pre_b_reg <= `PRE_RST;
         adc_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         amode_reg <= amode_next;
         bmode_reg <= bmode_next;
         ctl_reg <= ctl_next;
         imr_reg <= imr_next;
         ris_reg <= ris_next;
         ilr_a_reg <= ilr_a_next;
         ilr_b_reg <= ilr_b_next;
         match_reg <= match_next;
         pre_a_reg <= pre_a_next;
         pre_b_reg <= pre_b_next;
         adc_reg <= adc_next;
      end
   end

   // ==========================================================
   // rtc input: three-stage sync, edge detect, divide
   logic sync1_reg, sync2_reg, sync3_reg, stable_reg, stable_next;
   logic [DIV_W-1:0] div_reg, div_next;
   logic rtc_edge, rtc_tick, rtc_run, rtc_prev_reg;

   always_comb begin
      // a rising change counts only once stages two and three agree
      rtc_edge = (sync2_reg == sync3_reg) & sync3_reg & ~stable_reg; // [R24]
      stable_next = (sync2_reg == sync3_reg) ? sync3_reg : stable_reg;
      div_next = div_reg;
      rtc_tick = 1'b0;
      if (cfg_reg != `CFG_32_RTC || rtc_entry) begin
         div_next = '0;
      end else if (rtc_edge && rtc_run) begin
         if (div_reg == DIV_LAST) begin
            div_next = '0;
            rtc_tick = 1'b1; // [R20]
         end else begin
            div_next = div_reg + DIV_W'(1);
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         stable_reg <= 1'b0;
         div_reg <= '0;
         rtc_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= CAPTURE_PIN_EVEN_0;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         stable_reg <= stable_next;
         div_reg <= div_next;
         rtc_prev_reg <= (cfg_reg == `CFG_32_RTC);
      end
   end

   // ==========================================================
   // counting
   logic halt_a, halt_b, run_a, run_b, zero_a, zero_b;
   logic [31:0] joined;

   always_comb begin
      joined = {b_if.count, a_if.count};
      zero_a = (a_if.count == 16'h0000);
      zero_b = (b_if.count == 16'h0000);
      halt_a = DBG_HALT & ctl_reg[`CTL_A_STALL]; // [R18]
      halt_b = DBG_HALT & ctl_reg[`CTL_B_STALL];
      run_a = ctl_reg[`CTL_A_EN] & ~halt_a; // [R12]
      run_b = ctl_reg[`CTL_B_EN] & ~halt_b;
      // rtc ignores either stall bit when overridden
      rtc_run = ctl_reg[`CTL_A_EN] & ~(DBG_HALT
         & (ctl_reg[`CTL_A_STALL] | ctl_reg[`CTL_B_STALL])
         & ~ctl_reg[`CTL_RTC_OVR]); // [R23]
      rtc_entry = (cfg_reg == `CFG_32_RTC) & ~rtc_prev_reg;
      a_if.cmd = gtimer_pkg::CNT_HOLD;
      b_if.cmd = gtimer_pkg::CNT_HOLD;
      a_if.value = ilr_a_reg;
      b_if.value = ilr_b_reg;
      a_to = 1'b0;
      b_to = 1'b0;
      rtc_hit = 1'b0;
      a_done = 1'b0;
      b_done = 1'b0;
      case (cfg_reg)
         `CFG_32_TIMER: begin // [R3]
            if (ILR_A_WR) begin
               a_if.cmd = gtimer_pkg::CNT_LOAD; // [R17]
               b_if.cmd = gtimer_pkg::CNT_LOAD;
               a_if.value = ILR_A_WDATA[15:0];
               b_if.value = ILR_A_WDATA[31:16];
            end else if (run_a) begin
               if (joined == 32'h00000000) begin
                  a_if.cmd = gtimer_pkg::CNT_LOAD; // [R13]
                  b_if.cmd = gtimer_pkg::CNT_LOAD;
                  a_to = 1'b1;
                  a_done = (amode_reg != `MODE_PERIODIC); // [R11]
               end else begin
                  a_if.cmd = gtimer_pkg::CNT_DEC;
                  if (zero_a) b_if.cmd = gtimer_pkg::CNT_DEC;
               end
            end
         end
         `CFG_32_RTC: begin
            if (rtc_entry) begin
               a_if.cmd = gtimer_pkg::CNT_LOAD; // [R19]
               b_if.cmd = gtimer_pkg::CNT_LOAD;
               a_if.value = `RTC_FIRST_LO;
               b_if.value = `RTC_FIRST_HI;
            end else if (rtc_tick) begin
               if (joined == match_reg) begin
                  a_if.cmd = gtimer_pkg::CNT_LOAD; // [R21]
                  b_if.cmd = gtimer_pkg::CNT_LOAD;
                  a_if.value = `RTC_ROLL;
                  b_if.value = `RTC_ROLL;
                  rtc_hit = 1'b1; // [R22]
               end else begin
                  a_if.cmd = gtimer_pkg::CNT_INC;
                  if (a_if.count == 16'hFFFF) begin
                     b_if.cmd = gtimer_pkg::CNT_INC;
                  end
               end
            end
         end
         default: begin // [R8]
            if (ILR_A_WR) begin
               a_if.cmd = gtimer_pkg::CNT_LOAD;
               a_if.value = ILR_A_WDATA[15:0];
            end else if (run_a) begin
               if (zero_a) begin
                  a_if.cmd = gtimer_pkg::CNT_LOAD;
                  a_to = 1'b1;
                  a_done = (amode_reg != `MODE_PERIODIC);
               end else begin
                  a_if.cmd = gtimer_pkg::CNT_DEC;
               end
            end
            if (ILR_B_WR) begin
               b_if.cmd = gtimer_pkg::CNT_LOAD;
               b_if.value = ILR_B_WDATA;
            end else if (run_b) begin
               if (zero_b) begin
                  b_if.cmd = gtimer_pkg::CNT_LOAD;
                  b_to = 1'b1;
                  b_done = (bmode_reg != `MODE_PERIODIC);
               end else begin
                  b_if.cmd = gtimer_pkg::CNT_DEC;
               end
            end
         end
      endcase
   end

   // ==========================================================
   // outputs
   logic split;
   assign split = (cfg_reg == `CFG_16_SPLIT);
   assign TIMER_CONFIG_REG = cfg_reg;
   assign COUNTER_A_MODE_REG = amode_reg;
   assign COUNTER_B_MODE_REG = bmode_reg;
   assign TIMER_CONTROL_REG = ctl_reg;
   assign COUNTER_A_INTERVAL_LOAD = split ? {16'h0000, ilr_a_reg}
      : {ilr_b_reg, ilr_a_reg};
   assign COUNTER_B_INTERVAL_LOAD = ilr_b_reg;
   assign COUNTER_A_MATCH = match_reg;
   assign COUNTER_A_PRESCALE = pre_a_reg;
   assign COUNTER_B_PRESCALE = pre_b_reg;
   assign IRQ_MASK_REG = imr_reg;
   assign COUNTER_A_VALUE = split ? {16'h0000, a_if.count}
      : joined; // [R10]
   assign COUNTER_B_VALUE = b_if.count;
   assign RAW_IRQ_STATUS = ris_reg;
   assign MASKED_IRQ_STATUS = ris_reg & imr_reg; // [R15] [R22]
   assign IRQ = |(ris_reg & imr_reg);
   // shared converter trigger line
   assign ADC_TRIG = adc_reg | ADC_TRIG_IN; // [R2]
endmodule : general_timer_module
`default_nettype wire

// [tb/rtc_clock_source.sv]
// low-frequency clock source standing on the rtc capture pin
`timescale 1ns/1ps
`default_nettype none
module rtc_clock_source #(
   parameter int HALF_NS = 40
) (
   // control
   input wire logic enable,
   // pin
   output logic pin
);
   // phase offset keeps the pin unrelated to the system clock
   initial begin
      pin = 1'b0;
      #3.3;
      forever begin
         #(HALF_NS);
         pin = enable ? ~pin : 1'b0;
      end
   end
endmodule : rtc_clock_source
`default_nettype wire

// [tb/general_timer_module_assertions.sv]
// concurrent checks on the joined general-purpose timer ports
`timescale 1ns/1ps
`default_nettype none
module gtimer_checker (
   // clock and inputs
   input wire logic CLK,
   input wire logic RST,
   input wire logic DBG_HALT,
   input wire logic ADC_TRIG_IN,
   input wire logic CFG_WR,
   input wire logic [2:0] CFG_WDATA,
   input wire logic CTL_WR,
   input wire logic ILR_A_WR,
   input wire logic [31:0] ILR_A_WDATA,
   input wire logic ILR_B_WR,
   input wire logic ICR_WR,
   input wire logic [15:0] ICR_WDATA,
   // outputs
   input wire logic [2:0] TIMER_CONFIG_REG,
   input wire logic [1:0] COUNTER_A_MODE_REG,
   input wire logic [15:0] TIMER_CONTROL_REG,
   input wire logic [31:0] COUNTER_A_INTERVAL_LOAD,
   input wire logic [15:0] COUNTER_B_INTERVAL_LOAD,
   input wire logic [31:0] COUNTER_A_VALUE,
   input wire logic [15:0] COUNTER_B_VALUE,
   input wire logic [15:0] RAW_IRQ_STATUS,
   input wire logic [15:0] MASKED_IRQ_STATUS,
   input wire logic [15:0] IRQ_MASK_REG,
   input wire logic IRQ,
   input wire logic ADC_TRIG
);
   // ==========================================================
   // helpers
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   wire quiet = !ILR_A_WR && !ILR_B_WR && !CFG_WR && !CTL_WR;
   wire run = TIMER_CONFIG_REG == 3'h0 && TIMER_CONTROL_REG[0] &&
      !(DBG_HALT && TIMER_CONTROL_REG[1]) && quiet;
   sequence s_at_zero;
      run && COUNTER_A_VALUE == 32'h00000000;
   endsequence
   // ==========================================================
   // properties
   AST_RESET: assert property (disable iff (1'b0) RST |=>
      COUNTER_A_VALUE == 32'hFFFFFFFF && TIMER_CONTROL_REG == 16'h0000 &&
      COUNTER_A_INTERVAL_LOAD == 32'hFFFFFFFF && TIMER_CONFIG_REG == 3'h0)
      else $error("reset values wrong");
   AST_CFG: assert property (CFG_WR |=>
      TIMER_CONFIG_REG == $past(CFG_WDATA)) else $error("config not taken");
   AST_ILR_JOIN: assert property (ILR_A_WR && !ILR_B_WR && !CFG_WR &&
      TIMER_CONFIG_REG < 3'h2 |=> {COUNTER_B_INTERVAL_LOAD,
      COUNTER_A_INTERVAL_LOAD[15:0]} == $past(ILR_A_WDATA))
      else $error("joined load split wrong");
   AST_READ_JOIN: assert property (TIMER_CONFIG_REG < 3'h2 |->
      COUNTER_A_VALUE[31:16] == COUNTER_B_VALUE) else $error("joined read");
   AST_MASKED: assert property (MASKED_IRQ_STATUS ==
      (RAW_IRQ_STATUS & IRQ_MASK_REG) && IRQ == |MASKED_IRQ_STATUS)
      else $error("masked status wrong");
   AST_DOWN: assert property (run && COUNTER_A_VALUE != 32'h0 |=>
      COUNTER_A_VALUE == $past(COUNTER_A_VALUE) - 32'h1)
      else $error("count not decremented");
   AST_RELOAD: assert property (s_at_zero |=> RAW_IRQ_STATUS[0] &&
      COUNTER_A_VALUE == $past(COUNTER_A_INTERVAL_LOAD))
      else $error("no reload at zero");
   AST_ONESHOT: assert property ((s_at_zero and
      COUNTER_A_MODE_REG != 2'h2) |=> !TIMER_CONTROL_REG[0])
      else $error("one-shot kept running");
   AST_STALL: assert property (TIMER_CONFIG_REG == 3'h0 && DBG_HALT &&
      TIMER_CONTROL_REG[1] && quiet |=> $stable(COUNTER_A_VALUE))
      else $error("count moved in halt");
   AST_STICKY: assert property (RAW_IRQ_STATUS[0] &&
      !(ICR_WR && ICR_WDATA[0]) |=> RAW_IRQ_STATUS[0])
      else $error("timeout flag dropped");
   AST_TRIG: assert property ((s_at_zero and TIMER_CONTROL_REG[5]) |->
      ##[1:2] ADC_TRIG) else $error("no adc trigger");
   AST_TRIG_OR: assert property (ADC_TRIG_IN |-> ADC_TRIG)
      else $error("trigger input not passed");
   AST_RTC_FIRST: assert property (CFG_WR && CFG_WDATA == 3'h1 &&
      TIMER_CONFIG_REG != 3'h1 |-> ##[1:2] COUNTER_A_VALUE == 32'h1)
      else $error("rtc entry not loaded with one");
endmodule : gtimer_checker
`default_nettype wire

bind general_timer_module gtimer_checker gtimer_checker_inst (.CLK, .RST,
   .DBG_HALT, .ADC_TRIG_IN, .CFG_WR, .CFG_WDATA, .CTL_WR, .ILR_A_WR,
   .ILR_A_WDATA, .ILR_B_WR, .ICR_WR, .ICR_WDATA, .TIMER_CONFIG_REG,
   .COUNTER_A_MODE_REG, .TIMER_CONTROL_REG, .COUNTER_A_INTERVAL_LOAD,
   .COUNTER_B_INTERVAL_LOAD, .COUNTER_A_VALUE, .COUNTER_B_VALUE,
   .RAW_IRQ_STATUS, .MASKED_IRQ_STATUS, .IRQ_MASK_REG, .IRQ, .ADC_TRIG);

// [tb/tb_general_timer_module.sv]
// self-checking bench for the joined general-purpose timer
`timescale 1ns/1ps
`default_nettype none
module tb_general_timer_module;
   logic CLK, RST, dbg, trig_in, rtc_en, pin, IRQ, ADC_TRIG;
   logic [10:0] strobes;
   logic [31:0] wdata, ld, v, COUNTER_A_INTERVAL_LOAD, COUNTER_A_MATCH;
   logic [31:0] COUNTER_A_VALUE;
   logic [2:0] TIMER_CONFIG_REG;
   logic [1:0] COUNTER_A_MODE_REG, COUNTER_B_MODE_REG;
   logic [7:0] COUNTER_A_PRESCALE, COUNTER_B_PRESCALE;
   logic [15:0] TIMER_CONTROL_REG, COUNTER_B_INTERVAL_LOAD, IRQ_MASK_REG;
   logic [15:0] COUNTER_B_VALUE, RAW_IRQ_STATUS, MASKED_IRQ_STATUS;
   int miscompares = 0, tests_run = 0, cycles = 0, trig_seen = 0, n, seed;
   general_timer_module #(.RTC_DIV(4)) general_timer_module_inst (.CLK,
      .RST, .DBG_HALT(dbg), .ADC_TRIG_IN(trig_in), .CAPTURE_PIN_EVEN_0(pin),
      .CFG_WR(strobes[0]), .CFG_WDATA(wdata[2:0]), .A_MODE_WR(strobes[1]),
      .A_MODE_WDATA(wdata[1:0]), .B_MODE_WR(strobes[2]),
      .B_MODE_WDATA(wdata[1:0]), .CTL_WR(strobes[3]),
      .CTL_WDATA(wdata[15:0]), .ILR_A_WR(strobes[4]), .ILR_A_WDATA(wdata),
      .ILR_B_WR(strobes[10]), .ILR_B_WDATA(wdata[15:0]),
      .MATCH_A_WR(strobes[5]), .MATCH_A_WDATA(wdata), .PRE_A_WR(strobes[6]),
      .PRE_A_WDATA(wdata[7:0]), .PRE_B_WR(strobes[7]),
      .PRE_B_WDATA(wdata[7:0]), .IMR_WR(strobes[8]),
      .IMR_WDATA(wdata[15:0]), .ICR_WR(strobes[9]), .ICR_WDATA(wdata[15:0]),
      .TIMER_CONFIG_REG, .COUNTER_A_MODE_REG, .COUNTER_B_MODE_REG,
      .TIMER_CONTROL_REG, .COUNTER_A_INTERVAL_LOAD, .COUNTER_B_INTERVAL_LOAD,
      .COUNTER_A_MATCH, .COUNTER_A_PRESCALE, .COUNTER_B_PRESCALE,
      .IRQ_MASK_REG, .COUNTER_A_VALUE, .COUNTER_B_VALUE, .RAW_IRQ_STATUS,
      .MASKED_IRQ_STATUS, .IRQ, .ADC_TRIG);
   rtc_clock_source rtc_clock_source_inst (.enable(rtc_en), .pin(pin));
   // ==========================================================
   // clock, watchdog and trigger monitor
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cycles++;
      if (ADC_TRIG === 1'b1 && !trig_in) trig_seen++;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // ==========================================================
   // tasks
   // sel: 0 cfg,1 a mode,2 b mode,3 ctl,4 a load,5 match,6/7 prescale,
   // 8 mask,9 clear,10 b load
   task automatic wr(input int sel, input logic [31:0] d);
      @(posedge CLK);
      strobes <= 11'h001 << sel;
      wdata <= d;
      @(posedge CLK);
      strobes <= 11'h000;
   endtask : wr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_raw(input int b);
      n = 0;
      do begin
         @(posedge CLK);
         #1;
         n++;
      end while (RAW_IRQ_STATUS[b] !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         miscompares++;
         report_and_stop();
      end
   endtask : wait_raw
   // edges from the enabling write until the reload is visible
   function automatic int oneshot_edges(input logic [31:0] load);
      return int'(load) + 1;
   endfunction : oneshot_edges
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   // ==========================================================
   // main sequence
   initial begin
      seed = 64;
      {strobes, wdata, dbg, trig_in, rtc_en, RST} = '0;
      RST = 1'b1;
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      #1;
      check(COUNTER_A_VALUE, 32'hFFFFFFFF);
      check(COUNTER_A_INTERVAL_LOAD, 32'hFFFFFFFF);
      check({TIMER_CONTROL_REG, IRQ_MASK_REG}, 32'h0);
      check(TIMER_CONFIG_REG, 0);
      check({COUNTER_A_PRESCALE, COUNTER_B_PRESCALE}, 0);
      v = $random(seed);
      wr(6, v);
      wr(7, v >> 8);
      #1;
      check({COUNTER_A_PRESCALE, COUNTER_B_PRESCALE}, {v[7:0], v[15:8]});
      $display("reset and prescale done");
      ld = 32'h4 + ($random(seed) & 32'hF);
      wr(1, 1);
      wr(2, 2);
      #1;
      check({COUNTER_A_MODE_REG, COUNTER_B_MODE_REG}, 4'h6);
      wr(4, ld);
      wr(8, 1);
      wr(3, 32'h21);
      wait_raw(0);
      check(n, oneshot_edges(ld));
      check({COUNTER_A_VALUE, TIMER_CONTROL_REG[0]}, {ld, 1'b0});
      check({MASKED_IRQ_STATUS[0], IRQ}, 2'h3);
      repeat (3) @(posedge CLK);
      check(trig_seen, 1);
      wr(9, 1);
      #1;
      check({RAW_IRQ_STATUS[0], IRQ}, 2'h0);
      $display("one-shot done");
      wr(1, 2);
      wr(3, 1);
      wait_raw(0);
      wr(9, 1);
      wait_raw(0);
      check({TIMER_CONTROL_REG[0], trig_seen[3:0]}, 5'h11);
      wr(4, 32'h00010001);
      #1;
      check(COUNTER_A_VALUE, 32'h00010001);
      repeat (2) @(posedge CLK);
      #1;
      check(COUNTER_A_VALUE, 32'h0000FFFF);
      wr(3, 3);
      @(posedge CLK);
      dbg <= 1'b1;
      #1;
      v = COUNTER_A_VALUE;
      repeat (5) @(posedge CLK);
      #1;
      check(COUNTER_A_VALUE, v);
      dbg <= 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      check(COUNTER_A_VALUE, v - 32'h2);
      trig_in <= 1'b1;
      #1;
      check(ADC_TRIG, 1);
      trig_in <= 1'b0;
      wr(3, 0);
      $display("periodic, reload and stall done");
      v = $random(seed);
      wr(0, 4);
      wr(4, v);
      #1;
      check(COUNTER_A_INTERVAL_LOAD, {16'h0, v[15:0]});
      check(COUNTER_B_INTERVAL_LOAD, 16'h0001);
      wr(10, v >> 16);
      #1;
      check(COUNTER_B_INTERVAL_LOAD, v[31:16]);
      wr(10, 3);
      wr(3, 32'h100);
      wait_raw(8);
      check(n, oneshot_edges(3));
      check({COUNTER_B_VALUE, TIMER_CONTROL_REG}, 32'h00030100);
      wr(3, 0);
      $display("split done");
      wr(0, 1);
      @(posedge CLK);
      #1;
      check(COUNTER_A_VALUE, 32'h1);
      wr(5, 3);
      #1;
      check(COUNTER_A_MATCH, 3);
      wr(8, 32'h8);
      rtc_en = 1'b1;
      wr(3, 1);
      wait_raw(3);
      check(COUNTER_A_VALUE, 32'h0);
      check({MASKED_IRQ_STATUS[3], IRQ}, 2'h3);
      wr(3, 32'h13);
      dbg <= 1'b1;
      #1;
      v = COUNTER_A_VALUE;
      n = 0;
      while (COUNTER_A_VALUE === v && n < 200) begin
         @(posedge CLK);
         #1;
         n++;
      end
      check(COUNTER_A_VALUE !== v, 1);
      wr(3, 3);
      #1;
      v = COUNTER_A_VALUE;
      repeat (100) @(posedge CLK);
      #1;
      check(COUNTER_A_VALUE, v);
      wr(9, 32'h8);
      #1;
      check({RAW_IRQ_STATUS[3], MASKED_IRQ_STATUS[3], IRQ}, 0);
      $display("rtc done");
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      #1;
      check(COUNTER_A_VALUE, 32'hFFFFFFFF);
      check({TIMER_CONTROL_REG, RAW_IRQ_STATUS}, 32'h0);
      $display("second reset done");
      report_and_stop();
   end
endmodule : tb_general_timer_module
`default_nettype wire
